// >>> core/adaptive_brightness_cmds.v
// command interpreter for adaptive brightness mode and floor
`timescale 1ns/100ps
`default_nettype none
`include "adaptive_brightness_regs.vh"

// How it works
// - command 56h reads dummy byte, then the eight-bit adaptive mode.
// - mode byte encodes four content modes and three enhancement levels.
// - command 5Eh with one parameter stores the brightness floor.
// - with block on, adaptive enabled and mode not off, output brightness never below floor.
// - content processing keeps running while the floor holds brightness.
// - manual brightness is not limited by the floor.
// - smooth transition and dimming pass through untouched by the floor.
// - with brightness block off, the floor is ignored.
// - floor value is monotonic, 00h lowest and FFh highest.
// - command 5Fh reads dummy byte, then the stored floor.
// - parallel reads past the second keep returning the second byte.
// - over the serial link the dummy byte is omitted.
// - floor resets to 00h on hardware reset, kept on software reset.
// - commands accepted in every power and display state.
module adaptive_brightness_cmds (
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire       i_data_command_select,
  input  wire       i_write_strobe,
  input  wire       i_read_strobe,
  input  wire [7:0] i_data,
  input  wire       i_serial_link,
  input  wire       i_brightness_block_on,
  input  wire       i_adaptive_enable,
  input  wire [7:0] i_adaptive_brightness,
  input  wire [7:0] i_manual_brightness,
  output reg  [7:0] o_data,
  output wire       o_data_oe,
  output reg  [7:0] o_adaptive_mode_setting,
  output reg  [7:0] o_brightness_floor_value,
  output reg  [7:0] o_brightness,
  output wire       o_content_processing_on,
  output wire       o_floor_active
);

  // read states
  localparam RD_IDLE   = 2'd0;
  localparam RD_DUMMY  = 2'd1;
  localparam RD_VALUE  = 2'd2;

  // three-stage pin synchronisers, change seen when stages 2 and 3 agree
  reg  [2:0] dcx_sync_reg;
  reg  [2:0] wr_sync_reg;
  reg  [2:0] rd_sync_reg;
  reg  [7:0] dat_s1_reg;
  reg  [7:0] dat_s2_reg;
  reg  [7:0] dat_s3_reg;
  reg        wr_level_reg;
  reg        rd_level_reg;
  reg  [7:0] cmd_reg;
  reg        par_pending_reg;
  reg  [1:0] rd_state_reg;
  reg  [1:0] rd_state_next;
  reg  [7:0] rd_value_reg;
  reg        rd_active_reg;
  reg  [7:0] cmd_next;
  reg        par_pending_next;
  reg  [7:0] floor_next;
  reg  [7:0] mode_next;
  reg  [7:0] rd_value_next;
  reg  [7:0] rd_data_next;
  reg  [7:0] brightness_next;

  wire wr_stable = (wr_sync_reg[1] == wr_sync_reg[2]);
  wire rd_stable = (rd_sync_reg[1] == rd_sync_reg[2]);
  wire wr_rise   = wr_stable & wr_sync_reg[2] & ~wr_level_reg;
  wire rd_rise   = rd_stable & rd_sync_reg[2] & ~rd_level_reg;
  wire is_cmd    = ~dcx_sync_reg[2];

  function is_read_cmd;
    input [7:0] c;
    begin
      is_read_cmd = (c == `CMD_READ_MODE) || (c == `CMD_READ_FLOOR);
    end
  endfunction

  // reset to the idle-high level so no false edge follows reset
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      dcx_sync_reg <= 3'h0;
      wr_sync_reg  <= 3'h7;
      rd_sync_reg  <= 3'h7;
      wr_level_reg <= 1'b1;
      rd_level_reg <= 1'b1;
    end else begin
      dcx_sync_reg <= {dcx_sync_reg[1:0], i_data_command_select};
      wr_sync_reg  <= {wr_sync_reg[1:0], i_write_strobe};
      rd_sync_reg  <= {rd_sync_reg[1:0], i_read_strobe};
      if (wr_stable)
        wr_level_reg <= wr_sync_reg[2];
      if (rd_stable)
        rd_level_reg <= rd_sync_reg[2];
    end
  end

  // data bus takes the same three stages as the strobes
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      dat_s1_reg <= 8'h00;
      dat_s2_reg <= 8'h00;
      dat_s3_reg <= 8'h00;
    end else begin
      dat_s1_reg <= i_data;
      dat_s2_reg <= dat_s1_reg;
      dat_s3_reg <= dat_s2_reg;
    end
  end

  // command decode; no power-state gating at all
  always @* begin
    cmd_next         = cmd_reg;
    par_pending_next = par_pending_reg;
    floor_next       = o_brightness_floor_value;
    mode_next        = o_adaptive_mode_setting;
    if (wr_rise) begin
      if (is_cmd) begin
        cmd_next         = dat_s3_reg;
        par_pending_next = 1'b1;
      end else if (par_pending_reg) begin
        // only the first parameter counts, later ones fall through
        par_pending_next = 1'b0;
        if (cmd_reg == `CMD_WRITE_FLOOR)
          floor_next = dat_s3_reg;
        if (cmd_reg == `CMD_WRITE_MODE)
          mode_next = dat_s3_reg;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      cmd_reg                  <= 8'h00;
      par_pending_reg          <= 1'b0;
      o_adaptive_mode_setting  <= `MODE_RESET;
      o_brightness_floor_value <= `FLOOR_RESET;
    end else begin
      cmd_reg                  <= cmd_next;
      par_pending_reg          <= par_pending_next;
      o_adaptive_mode_setting  <= mode_next;
      o_brightness_floor_value <= floor_next;
    end
  end

  // read sequencing: dummy first on parallel, skipped on serial link
  always @* begin
    rd_state_next = rd_state_reg;
    if (wr_rise && is_cmd)
      rd_state_next = is_read_cmd(dat_s3_reg) ?
        (i_serial_link ? RD_VALUE : RD_DUMMY) : RD_IDLE;
    else if (rd_rise) begin
      case (rd_state_reg)
        RD_IDLE:  rd_state_next = RD_IDLE;
        RD_DUMMY: rd_state_next = RD_VALUE;
        RD_VALUE: rd_state_next = RD_VALUE;
        default:  rd_state_next = RD_IDLE;
      endcase
    end
  end

  // value source follows the last read command taken
  always @* begin
    case (cmd_reg)
      `CMD_READ_FLOOR: rd_value_next = o_brightness_floor_value;
      `CMD_READ_MODE:  rd_value_next = o_adaptive_mode_setting;
      default:         rd_value_next = 8'h00;
    endcase
  end

  // dummy byte is zero; value byte repeats on later strobes
  always @* begin
    if (rd_state_reg == RD_VALUE)
      rd_data_next = rd_value_reg;
    else
      rd_data_next = 8'h00;
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_state_reg  <= RD_IDLE;
      rd_value_reg  <= 8'h00;
      rd_active_reg <= 1'b0;
      o_data        <= 8'h00;
    end else begin
      rd_state_reg  <= rd_state_next;
      // bus let go as soon as the strobe is seen high again
      rd_active_reg <= (rd_state_reg != RD_IDLE) & ~rd_sync_reg[2];
      rd_value_reg  <= rd_value_next;
      o_data        <= rd_data_next;
    end
  end

  assign o_data_oe = rd_active_reg;

  // brightness path; unsigned compare keeps 00h lowest
  wire floor_apply = i_brightness_block_on & i_adaptive_enable &
                     (o_adaptive_mode_setting != `MODE_OFF);
  assign o_floor_active = floor_apply &
                          (i_adaptive_brightness < o_brightness_floor_value);
  // processing never gated by the clamp
  assign o_content_processing_on = i_adaptive_enable;

  // manual and dimmed value untouched when the block is on and the floor is out of play; block off drives 00h
  always @* begin
    brightness_next = i_adaptive_brightness;
    if (!i_brightness_block_on)
      brightness_next = 8'h00;
    else if (!floor_apply)
      brightness_next = i_manual_brightness;
    else if (o_floor_active)
      brightness_next = o_brightness_floor_value;
  end

  always @(posedge i_clk) begin
    if (!i_rst_b)
      o_brightness <= 8'h00;
    else
      o_brightness <= brightness_next;
  end

endmodule
`default_nettype wire

// >>> core/adaptive_brightness_regs.vh
// constants for the adaptive brightness command block
`ifndef ADAPTIVE_BRIGHTNESS_REGS_VH
`define ADAPTIVE_BRIGHTNESS_REGS_VH
`define CMD_WRITE_MODE        8'h55
`define CMD_READ_MODE         8'h56
`define CMD_WRITE_FLOOR       8'h5E
`define CMD_READ_FLOOR        8'h5F
`define MODE_RESET            8'h00
`define FLOOR_RESET           8'h00
`define MODE_OFF              8'h00
`define MODE_UI               8'h01
`define MODE_STILL            8'h02
`define MODE_MOVING           8'h03
`define MODE_ENH_LOW          8'h80
`define MODE_ENH_MED          8'h90
`define MODE_ENH_HIGH         8'hB0
`define MODE_ENH_BIT          7
`endif

// >>> test/abc_asserts.sv
// checker for the adaptive brightness commands
`timescale 1ns/100ps
`default_nettype none
module abc_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_write_strobe,
  input wire logic       i_read_strobe,
  input wire logic       i_brightness_block_on,
  input wire logic       i_adaptive_enable,
  input wire logic       o_data_oe,
  input wire logic       o_content_processing_on,
  input wire logic       o_floor_active,
  input wire logic [7:0] i_manual_brightness,
  input wire logic [7:0] o_adaptive_mode_setting,
  input wire logic [7:0] o_brightness_floor_value,
  input wire logic [7:0] o_brightness
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // 8 idle cycles outlast the input synchroniser
  sequence s_wr_idle; i_write_strobe [*8]; endsequence
  a_floor_reset: assert property ($rose(i_rst_b) |->
    o_brightness_floor_value == 8'h00) else $error("floor reset");
  a_floor_held: assert property (s_wr_idle |=>
    $stable(o_brightness_floor_value)) else $error("floor moved");
  a_mode_held: assert property (s_wr_idle |=>
    $stable(o_adaptive_mode_setting)) else $error("mode moved");
  a_clamp_min: assert property (i_brightness_block_on &&
    i_adaptive_enable && o_adaptive_mode_setting != 8'h00 |=>
    o_brightness >= $past(o_brightness_floor_value)) else $error("clamp");
  a_floor_flag: assert property (o_floor_active |=>
    o_brightness == $past(o_brightness_floor_value)) else $error("flag");
  a_manual_pass: assert property (i_brightness_block_on &&
    !i_adaptive_enable |=> o_brightness == $past(i_manual_brightness))
    else $error("manual");
  a_block_off: assert property (!i_brightness_block_on |=>
    o_brightness == 8'h00) else $error("block off");
  a_content_on: assert property (
    o_content_processing_on == i_adaptive_enable) else $error("content");
  a_bus_idle: assert property (i_read_strobe [*8] |=>
    !o_data_oe) else $error("bus driven");
endmodule
bind adaptive_brightness_cmds abc_asserts chk_i (.*);
`default_nettype wire

// >>> test/host_model.sv
// host model driving the parallel command bus
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_q,
  output var logic o_dcs = 1'b1,
  output var logic o_wr_b = 1'b1,
  output var logic o_rd_b = 1'b1,
  output var logic [7:0] o_d = 8'h00
);
  task automatic put(input logic s, input logic [7:0] v);
    @(posedge i_clk) #1 o_dcs = s;
    o_d = v;
    o_wr_b = 1'b0;
    repeat (6) @(posedge i_clk);
    #1 o_wr_b = 1'b1;
    repeat (6) @(posedge i_clk);
    #1 o_d = ~v; // released bus must not echo the byte
  endtask
  task automatic get(output logic [7:0] q);
    @(posedge i_clk) #1 o_rd_b = 1'b0;
    o_dcs = 1'b1;
    repeat (8) @(posedge i_clk);
    q = i_q;
    #1 o_rd_b = 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
// bench for the adaptive brightness commands
`timescale 1ns/100ps
`default_nettype none
`include "adaptive_brightness_regs.vh"
module tb;
  logic i_clk = 0, i_rst_b = 0, i_serial_link = 0, i_adaptive_enable = 0;
  logic i_brightness_block_on = 1;
  logic [7:0] i_adaptive_brightness = 8'h10, i_manual_brightness = 8'h05, q;
  wire logic i_data_command_select, i_write_strobe, i_read_strobe, o_data_oe;
  wire logic o_content_processing_on, o_floor_active;
  wire logic [7:0] o_data, o_adaptive_mode_setting, o_brightness_floor_value;
  wire logic [7:0] o_brightness, hd;
  wire logic [7:0] i_data = o_data_oe ? o_data : hd;
  int failures, check_count, cyc;
  logic [7:0] modes [7] = '{`MODE_OFF, `MODE_UI, `MODE_STILL, `MODE_MOVING,
    `MODE_ENH_LOW, `MODE_ENH_MED, `MODE_ENH_HIGH};
  adaptive_brightness_cmds dut (.*);
  host_model host (.i_clk, .i_q(i_data), .o_dcs(i_data_command_select),
    .o_wr_b(i_write_strobe), .o_rd_b(i_read_strobe), .o_d(hd));
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c, e);
    host.put(1'b0, c);
    host.get(q);
    chk(q, i_serial_link ? e : 8'h00);
  endtask
  task automatic go(input logic [7:0] e);
    repeat (4) @(posedge i_clk);
    chk(o_brightness, e);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    #1 i_rst_b = 1;
    rd(`CMD_READ_FLOOR, 8'h00);
    host.get(q);
    chk(q, `FLOOR_RESET);
    host.put(1'b0, `CMD_WRITE_FLOOR);
    host.put(1'b1, 8'hA5);
    host.put(1'b1, 8'h11);
    rd(`CMD_READ_FLOOR, 8'hA5);
    repeat (2) begin
      host.get(q);
      chk(q, 8'hA5);
    end
    i_serial_link = 1;
    foreach (modes[i]) begin
      host.put(1'b0, `CMD_WRITE_MODE);
      host.put(1'b1, modes[i]);
      rd(`CMD_READ_MODE, modes[i]);
      chk(o_adaptive_mode_setting, modes[i]);
    end
    i_adaptive_enable = 1;
    go(8'hA5);
    chk({7'h00, o_floor_active}, 8'h01);
    chk({7'h00, o_content_processing_on}, 8'h01);
    i_adaptive_brightness = 8'hF0;
    go(8'hF0);
    chk({7'h00, o_floor_active}, 8'h00);
    i_adaptive_enable = 0;
    go(8'h05);
    i_brightness_block_on = 0;
    go(8'h00);
    i_rst_b = 0;
    go(8'h00);
    i_rst_b = 1;
    chk(o_brightness_floor_value, `FLOOR_RESET);
    rd(`CMD_READ_FLOOR, `FLOOR_RESET);
    end_sim();
  end
endmodule
`default_nettype wire
